/* File: logic/scp_pkg.sv */
// Purpose: shared constants and types for the serial control pin logic
// Assumes: APB register access, two channels
// Notes:   register offsets are byte addresses of aligned 32-bit words
package scp_pkg;

  localparam int unsigned NUM_CH = 2;

  localparam logic [7:0] OFS_CTRL0  = 8'h00;
  localparam logic [7:0] OFS_CTRL1  = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQEN  = 8'h0c;
  localparam logic [7:0] OFS_VECTOR = 8'h10;
  localparam logic [7:0] OFS_TXDIV  = 8'h14;
  localparam logic [7:0] OFS_BUSADR = 8'h18;

  // Status register field positions
  localparam int unsigned ST_CHG_LSB  = 0;
  localparam int unsigned ST_LVL_LSB  = 4;
  localparam int unsigned ST_IUS_BIT  = 8;
  localparam int unsigned ST_PEND_BIT = 9;

  // Transmit bit rate may not exceed a quarter of pclk
  localparam logic [7:0] MIN_TX_DIV = 8'h04;

  localparam logic [7:0] RST_VECTOR = 8'h00;
  localparam logic [7:0] RST_TXDIV  = 8'h10;

  // Receive clock to data rate ratios, stored as count minus one
  localparam logic [5:0] MULT1_CNT  = 6'h00;
  localparam logic [5:0] MULT16_CNT = 6'h0f;
  localparam logic [5:0] MULT32_CNT = 6'h1f;
  localparam logic [5:0] MULT64_CNT = 6'h3f;

  typedef enum logic [1:0] {
    SCP_SRC_RX  = 2'b00,
    SCP_SRC_TX  = 2'b01,
    SCP_SRC_BRG = 2'b10,
    SCP_SRC_PLL = 2'b11
  } scp_src_t;

  typedef enum logic [1:0] {
    SCP_MULT1  = 2'b00,
    SCP_MULT16 = 2'b01,
    SCP_MULT32 = 2'b10,
    SCP_MULT64 = 2'b11
  } scp_mult_t;

  // Per-channel control word, low ten bits of CTRL0/CTRL1
  typedef struct packed {
    scp_mult_t rx_mult;
    logic      xtal;
    scp_src_t  clk_src;
    logic      dma_mode;
    logic      dtr_bit;
    logic      rts_bit;
    logic      async_mode;
    logic      auto_en;
  } scp_cfg_t;

  localparam scp_cfg_t RST_CFG = '0;

  // Serial engine facing signals of one channel
  typedef struct packed {
    logic tx_enable;
    logic rx_enable;
    logic tx_bit_en;
    logic rx_sample_en;
    logic clk_to_rx;
    logic clk_to_tx;
    logic clk_to_brg;
    logic clk_to_pll;
    logic xtal_osc_en;
  } scp_eng_t;

endpackage

/* File: logic/scp_pin_ctrl.sv */
// Purpose: modem lines, daisy chain, interrupt pin, strobe decode and clock pin steering
// Assumes: bus strobes synchronous to pclk, modem and clock pins asynchronous
// Notes:   serial engines, baud generator and PLL live elsewhere
// Function
// R1: Auto mode gates transmitter with clear-to-send
// R2: Detect both edges on modem inputs
// R3: Auto mode uses carrier-detect as receiver enable
// R4: Both strobes low means reset request
// R5: Terminal-ready output follows its control bit
// R6: Terminal-ready output may carry DMA request
// R7: Upstream drives chain enable when chain free
// R8: Chain out needs chain in, idle, quiet
// R9: Open-drain interrupt low while request pending; code releases it while ius is set, even with the request still pending
// R10: Drive vector on acknowledge with chain enabled
// R11: Latch acknowledge at address strobe rise
// R12: All internal logic runs on pclk
// R13: Transmit bit rate at most quarter pclk
// R14: Clock pin selectable as four sources
// R15: Clock pin may form crystal oscillator
// R16: Receive clock ratio 1,16,32 or 64
// R17: Setting request-to-send bit drives output low
// R18: Async auto: release waits for empty transmitter
// R19: Otherwise request-to-send follows bit immediately
// R20: Master drives read/write direction line
// R21: Latch address at address strobe rise
// R22: Synchronise modem inputs before edge detect
// R23: No vector while chain enable low
`timescale 1ns/100ps
module scp_pin_ctrl #(
  parameter int unsigned NCH = scp_pkg::NUM_CH
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic                            pready,
  output logic [31:0]                     prdata,
  output logic                            pslverr,
  input  wire logic                       addr_strobe_n,
  input  wire logic                       data_strobe_n,
  input  wire logic                       read_write,
  input  wire logic [7:0]                 ad_in,
  output logic [7:0]                      ad_out,
  output logic                            ad_oe,
  input  wire logic                       irq_ack_n,
  input  wire logic                       chain_enable_in,
  output logic                            chain_enable_out,
  output logic                            irq_n_out,
  output logic                            irq_n_oe,
  output logic                            bus_reset,
  output logic [7:0]                      bus_addr,
  output logic                            bus_read,
  input  wire logic [NCH-1:0]             cts_n,
  input  wire logic [NCH-1:0]             dcd_n,
  input  wire logic [NCH-1:0]             rx_tx_clock_pin,
  input  wire logic [NCH-1:0]             tx_empty,
  input  wire logic [NCH-1:0]             dma_req,
  output logic [NCH-1:0]                  rts_n,
  output logic [NCH-1:0]                  dtr_req_n,
  output scp_pkg::scp_eng_t [NCH-1:0]     eng
);

  typedef struct packed {
    scp_pkg::scp_cfg_t [NCH-1:0]  cfg;
    logic [NCH-1:0][7:0]          txdiv;
    logic [NCH-1:0][7:0]          txcnt;
    logic [NCH-1:0][5:0]          rxcnt;
    logic [NCH-1:0]               cts_s1;
    logic [NCH-1:0]               cts_s2;
    logic [NCH-1:0]               cts_d;
    logic [NCH-1:0]               dcd_s1;
    logic [NCH-1:0]               dcd_s2;
    logic [NCH-1:0]               dcd_d;
    logic [NCH-1:0]               clk_s1;
    logic [NCH-1:0]               clk_s2;
    logic [NCH-1:0]               clk_d;
    logic [NCH-1:0]               rts_drive;
    logic [NCH-1:0]               dtr_drive;
    scp_pkg::scp_eng_t [NCH-1:0]  eng;
    logic [2*NCH-1:0]             chg;
    logic [2*NCH-1:0]             irq_en;
    logic [7:0]                   vector;
    logic                         ius;
    logic                         as_d;
    logic                         ds_d;
    logic                         ack;
    logic [7:0]                   addr;
    logic                         rd;
    logic                         bus_rst;
    logic [31:0]                  rdata;
    logic                         slverr;
  } scp_st_t;

  scp_st_t st_r;
  scp_st_t st_nxt;

  logic                           apb_wr;
  logic                           apb_rd;
  logic                           pending;
  logic                           strobe_rst;
  logic                           ds_active;

  function automatic logic [5:0] mult_last(input scp_pkg::scp_mult_t m);
    unique case (m)
      scp_pkg::SCP_MULT1:  mult_last = scp_pkg::MULT1_CNT;
      scp_pkg::SCP_MULT16: mult_last = scp_pkg::MULT16_CNT;
      scp_pkg::SCP_MULT32: mult_last = scp_pkg::MULT32_CNT;
      scp_pkg::SCP_MULT64: mult_last = scp_pkg::MULT64_CNT;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == scp_pkg::OFS_CTRL0) || (a == scp_pkg::OFS_CTRL1) || (a == scp_pkg::OFS_STATUS) ||
             (a == scp_pkg::OFS_IRQEN) || (a == scp_pkg::OFS_VECTOR) || (a == scp_pkg::OFS_TXDIV) ||
             (a == scp_pkg::OFS_BUSADR);
  endfunction

  // Zero-wait slave: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign apb_wr  = psel && penable && pwrite;
  assign apb_rd  = psel && !penable && !pwrite;
  assign prdata  = st_r.rdata;
  assign pslverr = st_r.slverr && psel && penable;

  // R4 strobe reset
  assign strobe_rst = !addr_strobe_n && !data_strobe_n;
  assign ds_active  = !data_strobe_n && addr_strobe_n;

  always_comb begin
    logic [31:0]             status;
    logic [2*NCH-1:0]        rise_fall;
    logic [2*NCH-1:0]        chg_clr;
    logic [7:0]              div;
    logic                    clk_rise;
    status    = '0;
    rise_fall = '0;
    chg_clr   = '0;
    div       = '0;
    clk_rise  = 1'b0;
    st_nxt    = st_r;

    // R12 single clock, R22 two-flop synchronisers
    st_nxt.cts_s1 = cts_n;
    st_nxt.cts_s2 = st_r.cts_s1;
    st_nxt.cts_d  = st_r.cts_s2;
    st_nxt.dcd_s1 = dcd_n;
    st_nxt.dcd_s2 = st_r.dcd_s1;
    st_nxt.dcd_d  = st_r.dcd_s2;
    st_nxt.clk_s1 = rx_tx_clock_pin;
    st_nxt.clk_s2 = st_r.clk_s1;
    st_nxt.clk_d  = st_r.clk_s2;

    for (int c = 0; c < NCH; c++) begin
      // R2 both edges
      rise_fall[2*c]   = st_r.cts_s2[c] ^ st_r.cts_d[c];
      rise_fall[2*c+1] = st_r.dcd_s2[c] ^ st_r.dcd_d[c];
      status[scp_pkg::ST_LVL_LSB+2*c]   = st_r.cts_s2[c];
      status[scp_pkg::ST_LVL_LSB+2*c+1] = st_r.dcd_s2[c];
    end
    status[scp_pkg::ST_CHG_LSB +: 2*NCH] = st_r.chg;
    status[scp_pkg::ST_IUS_BIT]          = st_r.ius;
    status[scp_pkg::ST_PEND_BIT]         = pending;

    st_nxt.rdata  = '0;
    st_nxt.slverr = 1'b0;
    if (apb_rd) begin
      st_nxt.slverr = !mapped(paddr);
      unique case (paddr)
        scp_pkg::OFS_CTRL0:  st_nxt.rdata = 32'(st_r.cfg[0]);
        scp_pkg::OFS_CTRL1:  st_nxt.rdata = 32'(st_r.cfg[NCH-1]);
        scp_pkg::OFS_STATUS: st_nxt.rdata = status;
        scp_pkg::OFS_IRQEN:  st_nxt.rdata = 32'(st_r.irq_en);
        scp_pkg::OFS_VECTOR: st_nxt.rdata = 32'(st_r.vector);
        scp_pkg::OFS_TXDIV:  st_nxt.rdata = 32'(st_r.txdiv);
        scp_pkg::OFS_BUSADR: st_nxt.rdata = {23'h000000, st_r.rd, st_r.addr};
        default:             st_nxt.rdata = '0;
      endcase
    end
    if (psel && !penable && pwrite) begin
      st_nxt.slverr = !mapped(paddr);
    end

    if (apb_wr) begin
      unique case (paddr)
        scp_pkg::OFS_CTRL0:  st_nxt.cfg[0]     = pwdata[$bits(scp_pkg::scp_cfg_t)-1:0];
        scp_pkg::OFS_CTRL1:  st_nxt.cfg[NCH-1] = pwdata[$bits(scp_pkg::scp_cfg_t)-1:0];
        scp_pkg::OFS_STATUS: chg_clr           = pwdata[scp_pkg::ST_CHG_LSB +: 2*NCH];
        scp_pkg::OFS_IRQEN:  st_nxt.irq_en     = pwdata[2*NCH-1:0];
        scp_pkg::OFS_VECTOR: st_nxt.vector     = pwdata[7:0];
        scp_pkg::OFS_TXDIV:  st_nxt.txdiv      = pwdata[8*NCH-1:0];
        default:             st_nxt.vector     = st_r.vector;
      endcase
      // Writing one to the service bit ends the interrupt service
      if (paddr == scp_pkg::OFS_STATUS && pwdata[scp_pkg::ST_IUS_BIT]) begin
        st_nxt.ius = 1'b0;
      end
    end
    // A new edge beats a clear in the same cycle
    st_nxt.chg = (st_r.chg & ~chg_clr) | rise_fall;

    // R21 address latch, R11 acknowledge latch
    st_nxt.as_d = addr_strobe_n;
    st_nxt.ds_d = data_strobe_n;
    if (addr_strobe_n && !st_r.as_d && data_strobe_n) begin
      st_nxt.addr = ad_in;
      // R20 direction from master
      st_nxt.rd   = read_write;
      st_nxt.ack  = !irq_ack_n;
    end
    // R10 vector placed: device enters service
    if (st_r.ack && ds_active && st_r.ds_d && chain_enable_in && pending) begin
      st_nxt.ius = 1'b1;
    end

    for (int c = 0; c < NCH; c++) begin
      // R17 set drives low, R18 async auto waits for empty, R19 otherwise immediate
      if (st_r.cfg[c].rts_bit) begin
        st_nxt.rts_drive[c] = 1'b1;
      end else if (st_r.cfg[c].async_mode && st_r.cfg[c].auto_en) begin
        st_nxt.rts_drive[c] = st_r.rts_drive[c] && !tx_empty[c];
      end else begin
        st_nxt.rts_drive[c] = 1'b0;
      end
      // R5 control bit, R6 DMA request
      st_nxt.dtr_drive[c] = st_r.cfg[c].dma_mode ? dma_req[c] : st_r.cfg[c].dtr_bit;

      // R1 transmitter gate, R3 receiver gate
      st_nxt.eng[c].tx_enable = !st_r.cfg[c].auto_en || !st_r.cts_s2[c];
      st_nxt.eng[c].rx_enable = !st_r.cfg[c].auto_en || !st_r.dcd_s2[c];

      // R13 divisor floored at four
      div = (st_r.txdiv[c] < scp_pkg::MIN_TX_DIV) ? scp_pkg::MIN_TX_DIV : st_r.txdiv[c];
      st_nxt.eng[c].tx_bit_en = 1'b0;
      if (st_r.txcnt[c] >= div - 8'h01) begin
        st_nxt.txcnt[c]         = '0;
        st_nxt.eng[c].tx_bit_en = st_r.eng[c].tx_enable;
      end else begin
        st_nxt.txcnt[c] = st_r.txcnt[c] + 8'h01;
      end

      // R14 clock pin steering, R15 crystal enable; the steering outputs still follow the pin
      st_nxt.eng[c].xtal_osc_en = st_r.cfg[c].xtal;
      st_nxt.eng[c].clk_to_rx   = st_r.cfg[c].clk_src == scp_pkg::SCP_SRC_RX  && st_r.clk_s2[c];
      st_nxt.eng[c].clk_to_tx   = st_r.cfg[c].clk_src == scp_pkg::SCP_SRC_TX  && st_r.clk_s2[c];
      st_nxt.eng[c].clk_to_brg  = st_r.cfg[c].clk_src == scp_pkg::SCP_SRC_BRG && st_r.clk_s2[c];
      st_nxt.eng[c].clk_to_pll  = st_r.cfg[c].clk_src == scp_pkg::SCP_SRC_PLL && st_r.clk_s2[c];

      // R16 receive sample every 1, 16, 32 or 64 rising clock pin edges
      clk_rise = st_r.clk_s2[c] && !st_r.clk_d[c] && st_r.cfg[c].clk_src == scp_pkg::SCP_SRC_RX &&
                 !st_r.cfg[c].xtal;
      st_nxt.eng[c].rx_sample_en = 1'b0;
      if (clk_rise) begin
        if (st_r.rxcnt[c] >= mult_last(st_r.cfg[c].rx_mult)) begin
          st_nxt.rxcnt[c]            = '0;
          st_nxt.eng[c].rx_sample_en = st_r.eng[c].rx_enable;
        end else begin
          st_nxt.rxcnt[c] = st_r.rxcnt[c] + 6'h01;
        end
      end
    end

    // R4 strobe reset clears control and interrupt state
    st_nxt.bus_rst = strobe_rst;
    if (strobe_rst) begin
      st_nxt.cfg    = {NCH{scp_pkg::RST_CFG}};
      st_nxt.chg    = '0;
      st_nxt.irq_en = '0;
      st_nxt.ius    = 1'b0;
      st_nxt.ack    = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r        <= '0;
      st_r.vector <= scp_pkg::RST_VECTOR;
      st_r.txdiv  <= {NCH{scp_pkg::RST_TXDIV}};
      st_r.cts_s1 <= '1;
      st_r.cts_s2 <= '1;
      st_r.cts_d  <= '1;
      st_r.dcd_s1 <= '1;
      st_r.dcd_s2 <= '1;
      st_r.dcd_d  <= '1;
      st_r.as_d   <= 1'b1;
      st_r.ds_d   <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pending = |(st_r.chg & st_r.irq_en);

  // R9 open drain request
  assign irq_n_out = 1'b0;
  assign irq_n_oe  = pending && !st_r.ius;

  // R8 chain out; R7 upstream sets chain in
  assign chain_enable_out = chain_enable_in && !st_r.ius && !(st_r.ack && pending);

  // R10 drive vector, R23 never without chain enable
  assign ad_oe  = st_r.ack && ds_active && chain_enable_in && (pending || st_r.ius);
  assign ad_out = st_r.vector;

  assign bus_reset = st_r.bus_rst;
  assign bus_addr  = st_r.addr;
  assign bus_read  = st_r.rd;
  assign rts_n     = ~st_r.rts_drive;
  assign dtr_req_n = ~st_r.dtr_drive;
  assign eng       = st_r.eng;

endmodule

/* File: dv/scp_props.sv */
// Purpose: port-level checks of the serial control pin logic
// Assumes: one pclk domain, presetn asynchronous active low
// Notes:   bound into every instance of the pin logic
`timescale 1ns/100ps
module scp_props #(
  parameter int unsigned NCH = 2
) (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        addr_strobe_n,
  input wire logic                        data_strobe_n,
  input wire logic                        read_write,
  input wire logic [7:0]                  ad_in,
  input wire logic                        ad_oe,
  input wire logic                        chain_enable_in,
  input wire logic                        chain_enable_out,
  input wire logic                        irq_n_out,
  input wire logic                        irq_n_oe,
  input wire logic                        bus_reset,
  input wire logic [7:0]                  bus_addr,
  input wire logic                        bus_read,
  input wire scp_pkg::scp_eng_t [NCH-1:0] eng
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  bus_rst_a: assert property (!addr_strobe_n && !data_strobe_n |=> bus_reset)
    else $error("strobe reset not seen");
  rst_cause_a: assert property (bus_reset |-> $past(!addr_strobe_n && !data_strobe_n))
    else $error("bus reset without both strobes");
  chain_gate_a: assert property (chain_enable_out |-> chain_enable_in)
    else $error("chain out high with chain in low");
  vec_gate_a: assert property (ad_oe |-> chain_enable_in && !data_strobe_n && addr_strobe_n)
    else $error("vector driven out of turn");
  svc_block_a: assert property (ad_oe |=> !chain_enable_out && !irq_n_oe)
    else $error("service did not block chain");
  irq_pin_a: assert property (irq_n_oe |-> !irq_n_out)
    else $error("interrupt pin not pulled low");
  addr_latch_a: assert property ($rose(addr_strobe_n) && data_strobe_n
    |=> bus_addr == $past(ad_in) && bus_read == $past(read_write)) else $error("address not latched");
  tx_rate0_a: assert property (eng[0].tx_bit_en |=> (!eng[0].tx_bit_en) [*3])
    else $error("channel 0 bit rate too high");
  tx_rate1_a: assert property (eng[NCH-1].tx_bit_en |=> (!eng[NCH-1].tx_bit_en) [*3])
    else $error("channel 1 bit rate too high");

  cover property (ad_oe);
  cover property (bus_reset);
  cover property (eng[0].tx_bit_en);
endmodule

bind scp_pin_ctrl scp_props #(.NCH(NCH)) u_props (.*);

/* File: dv/scp_host_model.sv */
// Purpose: host side of the strobe bus and upstream daisy chain
// Assumes: strobes synchronous to pclk
// Notes:   released address lines show the inverse of the last value
`timescale 1ns/100ps
module scp_host_model (
  input  wire logic  pclk,
  output logic       addr_strobe_n,
  output logic       data_strobe_n,
  output logic       read_write,
  output logic [7:0] ad_in,
  output logic       irq_ack_n,
  output logic       chain_enable_in
);
  initial begin
    addr_strobe_n = 1'b1;
    data_strobe_n = 1'b1;
    read_write = 1'b1;
    ad_in = 8'hff;
    irq_ack_n = 1'b1;
    chain_enable_in = 1'b1;
  end

  task automatic cycle(input logic [7:0] a, input logic rd, input logic ack, input logic up);
    @(posedge pclk);
    addr_strobe_n <= 1'b0;
    ad_in <= a;
    read_write <= rd;
    irq_ack_n <= ack;
    @(posedge pclk);
    addr_strobe_n <= 1'b1;
    @(posedge pclk);
    ad_in <= ~a;
    chain_enable_in <= up;
    data_strobe_n <= 1'b0;
    repeat (2) @(posedge pclk);
    data_strobe_n <= 1'b1;
    irq_ack_n <= 1'b1;
    chain_enable_in <= 1'b1;
    @(posedge pclk);
  endtask

  task automatic strobe_reset();
    @(posedge pclk);
    addr_strobe_n <= 1'b0;
    data_strobe_n <= 1'b0;
    repeat (2) @(posedge pclk);
    addr_strobe_n <= 1'b1;
    data_strobe_n <= 1'b1;
  endtask
endmodule

/* File: dv/testbench.sv */
// Purpose: self-checking bench of the serial control pin logic
// Assumes: zero-wait APB slave, host model on the strobe bus
// Notes:   modem and clock pins are driven from here
`timescale 1ns/100ps
module testbench;
  logic                        pclk, presetn, psel, penable, pwrite, pready, pslverr, slv_err;
  logic [7:0]                  paddr, ad_out, bus_addr, vec_seen;
  logic [31:0]                 pwdata, prdata;
  logic                        addr_strobe_n, data_strobe_n, read_write, irq_ack_n, chain_enable_in;
  logic [7:0]                  ad_in;
  logic                        ad_oe, chain_enable_out, irq_n_out, irq_n_oe, bus_reset, bus_read;
  logic [1:0]                  cts_n, dcd_n, rx_tx_clock_pin, tx_empty, dma_req, rts_n, dtr_req_n;
  scp_pkg::scp_eng_t [1:0]     eng;
  int                          num_errors, n_compared, oe_hits, k;

  scp_pin_ctrl #(.NCH(2)) DUT (.*);
  scp_host_model host (.*);

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  always @(posedge pclk) if (ad_oe === 1'b1) begin
    vec_seen <= ad_out;
    oe_hits <= oe_hits + 1;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    slv_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(a, 1'b1, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(a, 1'b0, 32'h0, q);
    chk(q, e);
  endtask

  task automatic t_regs();
    rd(scp_pkg::OFS_TXDIV, 32'h1010);
    rd(8'h1c, 32'h0);
    chk(32'(slv_err), 32'h1);
  endtask

  task automatic t_rts();
    wr(scp_pkg::OFS_CTRL0, 32'h4);
    repeat (2) @(posedge pclk);
    chk(32'(rts_n), 32'h2);
    wr(scp_pkg::OFS_CTRL0, 32'h0);
    repeat (2) @(posedge pclk);
    chk(32'(rts_n), 32'h3);
    tx_empty <= 2'b10;
    wr(scp_pkg::OFS_CTRL0, 32'h7);
    wr(scp_pkg::OFS_CTRL0, 32'h3);
    repeat (4) @(posedge pclk);
    chk(32'(rts_n), 32'h2);
    tx_empty <= 2'b11;
    repeat (2) @(posedge pclk);
    chk(32'(rts_n), 32'h3);
  endtask

  task automatic t_dtr();
    wr(scp_pkg::OFS_CTRL1, 32'h8);
    repeat (2) @(posedge pclk);
    chk(32'(dtr_req_n), 32'h1);
    dma_req <= 2'b10;
    wr(scp_pkg::OFS_CTRL1, 32'h10);
    repeat (2) @(posedge pclk);
    chk(32'(dtr_req_n), 32'h1);
    dma_req <= 2'b00;
    repeat (2) @(posedge pclk);
    chk(32'(dtr_req_n), 32'h3);
  endtask

  // Each edge of each pin must leave exactly its own sticky bit
  task automatic t_modem();
    logic [3:0] lv;
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 2; j++) begin
        lv = j ? 4'hf : ~(4'h1 << i);
        if (i % 2) dcd_n[i/2] <= lv[i];
        else cts_n[i/2] <= lv[i];
        repeat (5) @(posedge pclk);
        rd(scp_pkg::OFS_STATUS, (32'(lv) << 4) | (32'h1 << i));
        wr(scp_pkg::OFS_STATUS, 32'h1 << i);
      end
    end
  endtask

  task automatic t_auto();
    wr(scp_pkg::OFS_CTRL0, 32'h1);
    repeat (4) @(posedge pclk);
    chk(32'({eng[0].tx_enable, eng[0].rx_enable}), 32'h0);
    cts_n <= 2'b10;
    dcd_n <= 2'b10;
    repeat (5) @(posedge pclk);
    chk(32'({eng[0].tx_enable, eng[0].rx_enable}), 32'h3);
    cts_n <= 2'b11;
    dcd_n <= 2'b11;
    wr(scp_pkg::OFS_CTRL0, 32'h0);
    repeat (5) @(posedge pclk);
    chk(32'({eng[0].tx_enable, eng[0].rx_enable}), 32'h3);
    wr(scp_pkg::OFS_STATUS, 32'hf);
  endtask

  task automatic t_irq();
    wr(scp_pkg::OFS_IRQEN, 32'h1);
    wr(scp_pkg::OFS_VECTOR, 32'ha5);
    cts_n <= 2'b10;
    repeat (5) @(posedge pclk);
    chk(32'(irq_n_oe), 32'h1);
    host.cycle(8'h00, 1'b1, 1'b0, 1'b0);
    chk(32'(oe_hits), 32'h0);
    host.cycle(8'h00, 1'b1, 1'b1, 1'b1);
    chk(32'(oe_hits), 32'h0);
    host.cycle(8'h00, 1'b1, 1'b0, 1'b1);
    chk(32'(vec_seen), 32'ha5);
    chk(32'({chain_enable_out, irq_n_oe}), 32'h0);
    wr(scp_pkg::OFS_STATUS, 32'h101);
    repeat (2) @(posedge pclk);
    chk(32'({chain_enable_out, irq_n_oe}), 32'h2);
  endtask

  task automatic t_bus();
    host.cycle(8'h3c, 1'b1, 1'b1, 1'b1);
    rd(scp_pkg::OFS_BUSADR, 32'h13c);
    host.cycle(8'h5a, 1'b0, 1'b1, 1'b1);
    rd(scp_pkg::OFS_BUSADR, 32'h05a);
    wr(scp_pkg::OFS_CTRL0, 32'h4);
    host.strobe_reset();
    rd(scp_pkg::OFS_CTRL0, 32'h0);
  endtask

  task automatic t_clk();
    rx_tx_clock_pin <= 2'b01;
    for (int s = 0; s < 4; s++) begin
      wr(scp_pkg::OFS_CTRL0, 32'(s) << 5);
      repeat (4) @(posedge pclk);
      chk(32'({eng[0].clk_to_rx, eng[0].clk_to_tx, eng[0].clk_to_brg, eng[0].clk_to_pll}), 32'h8 >> s);
    end
    wr(scp_pkg::OFS_CTRL0, 32'h80);
    repeat (2) @(posedge pclk);
    chk(32'(eng[0].xtal_osc_en), 32'h1);
    // A divisor of two must still be slowed to four cycles
    wr(scp_pkg::OFS_TXDIV, 32'h0202);
    for (k = 0; k < 50 && eng[0].tx_bit_en !== 1'b1; k++) @(posedge pclk);
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (eng[0].tx_bit_en !== 1'b1 && k < 50);
    chk(32'(k), 32'h4);
  endtask

  // Thirty-two synced rising pin edges at ratio 16 must give exactly two sample pulses
  task automatic t_rx();
    int n;
    n = 0;
    wr(scp_pkg::OFS_CTRL0, 32'h100);
    for (int i = 0; i < 140; i++) begin
      rx_tx_clock_pin[0] <= (i < 128) ? i[1] : 1'b0;
      @(posedge pclk);
      n += int'(eng[0].rx_sample_en);
    end
    chk(32'(n), 32'h2);
  endtask

  task automatic close_out();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Whole sequence needs about four hundred cycles
  initial begin
    #1000000;
    num_errors++;
    close_out();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {cts_n, dcd_n, tx_empty} = 6'h3f;
    {rx_tx_clock_pin, dma_req} = 4'h0;
    {oe_hits, num_errors, n_compared, vec_seen} = '0;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_rts();
    t_dtr();
    t_modem();
    t_auto();
    t_irq();
    t_bus();
    t_clk();
    t_rx();
    close_out();
  end
endmodule
